// ==== pkg/emu_pkg.sv ====
// Package of constants and types for the MII Ethernet MAC with management.
// Assumes a single 100 MHz system clock.
package emu_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int MGMT_PERIOD_NS = 400;
    localparam int MGMT_DIV_RST = (MGMT_PERIOD_NS / CLK_PERIOD_NS) / 2;
    localparam int DIV_W = 8;
    localparam int SYNC_STAGES = 2;
    // ****************************************
    // Management frame layout
    // ****************************************
    localparam int START_BITS = 2;
    localparam int OP_BITS = 2;
    localparam int PHY_ADDR_W = 5;
    localparam int REG_ADDR_W = 5;
    localparam int TA_BITS = 2;
    localparam int MGMT_DATA_W = 16;
    localparam int MGMT_HDR_W = START_BITS + OP_BITS + PHY_ADDR_W
        + REG_ADDR_W + TA_BITS;
    localparam int MGMT_FRAME_W = MGMT_HDR_W + MGMT_DATA_W;
    localparam logic [1:0] MGMT_START = 2'h1;
    localparam logic [1:0] MGMT_OP_RD = 2'h2;
    localparam logic [1:0] MGMT_OP_WR = 2'h1;
    localparam logic [1:0] MGMT_TA_WR = 2'h2;
    // ****************************************
    // Packet byte stream and engine states
    // ****************************************
    localparam int NIB_W = 4;
    localparam int BYTE_W = 8;
    typedef enum {TXS_IDLE, TXS_LO, TXS_HI} emu_tx_state_t;
    typedef enum {MGS_IDLE, MGS_SHIFT} emu_mgmt_state_t;
endpackage

// ==== hdl/emu_sync.sv ====
// Two flop level synchroniser for inputs that may be asynchronous.
// Assumes the destination clock is i_clk.
`timescale 1ns/10ps
module emu_sync
    import emu_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Level
    input wire logic i_async,
    output logic o_sync
);
    typedef struct packed {
        logic meta;
        logic sync;
    } emu_sync_st_t;
    emu_sync_st_t st_ff;
    emu_sync_st_t nxt_st;

    // Only the second stage reads the first.
    always_comb begin
        nxt_st.meta = i_async;
        nxt_st.sync = st_ff.meta;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_sync = st_ff.sync;
endmodule

// ==== hdl/emu_mac.sv ====
// MII Ethernet MAC datapath with a management serial port.
// Assumes PHY clocks arrive as ordinary inputs sampled on i_clk.
`timescale 1ns/10ps
module emu_mac
    import emu_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Configuration
    input wire logic i_full_duplex,
    input wire logic [DIV_W-1:0] i_mgmt_clock_divider,
    // Transmit byte stream
    input wire logic i_tx_valid,
    input wire logic [BYTE_W-1:0] i_tx_byte,
    input wire logic i_tx_last,
    output logic o_tx_ready,
    output logic o_tx_dma_req,
    // Receive byte stream
    output logic o_rx_valid,
    output logic [BYTE_W-1:0] o_rx_byte,
    output logic o_rx_done,
    output logic o_rx_frame_err,
    output logic o_rx_dma_req,
    // MII transmit
    input wire logic i_phy_tx_clock_in,
    output logic [NIB_W-1:0] o_tx_nibble_out,
    output logic o_tx_enable_out,
    output logic o_tx_error_out,
    input wire logic i_collision_in,
    input wire logic i_carrier_sense_in,
    // MII receive
    input wire logic i_phy_rx_clock_in,
    input wire logic [NIB_W-1:0] i_rx_nibble_in,
    input wire logic i_rx_valid_in,
    input wire logic i_rx_error_in,
    // Management command
    input wire logic i_mgmt_start,
    input wire logic i_mgmt_read,
    input wire logic [PHY_ADDR_W-1:0] i_mgmt_phy,
    input wire logic [REG_ADDR_W-1:0] i_mgmt_reg,
    input wire logic [MGMT_DATA_W-1:0] i_mgmt_wdata,
    output logic o_mgmt_busy,
    output logic o_mgmt_done,
    output logic [MGMT_DATA_W-1:0] o_mgmt_rdata,
    // Management pins
    output logic o_mgmt_clock_pin,
    input wire logic i_mgmt_data,
    output logic o_mgmt_data,
    output logic o_mgmt_data_oe_n
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic txc_d;
        logic rxc_d;
        emu_tx_state_t tx_st;
        logic [BYTE_W-1:0] tx_buf;
        logic tx_last;
        logic [NIB_W-1:0] tx_nib;
        logic tx_en;
        logic tx_req;
        logic rx_hi;
        logic [NIB_W-1:0] rx_lo;
        logic rx_err;
        logic rx_dv_d;
        logic rx_v;
        logic [BYTE_W-1:0] rx_byte;
        logic rx_done;
        logic rx_ferr;
        emu_mgmt_state_t mg_st;
        logic [DIV_W-1:0] mg_div;
        logic mg_clk;
        logic [MGMT_FRAME_W-1:0] mg_sh;
        logic [5:0] mg_cnt;
        logic mg_rd;
        logic [MGMT_DATA_W-1:0] mg_rdata;
        logic mg_done;
    } emu_st_t;
    emu_st_t st_ff;
    emu_st_t nxt_st;
    logic col_s;
    logic crs_s;
    logic tx_edge;
    logic rx_edge;
    logic mg_tick;
    logic can_start;
    logic [DIV_W-1:0] half_div;

    // ****************************************
    // Synchronisers
    // ****************************************
    emu_sync u_col_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async(i_collision_in),
        .o_sync(col_s)
    );
    emu_sync u_crs_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async(i_carrier_sense_in),
        .o_sync(crs_s)
    );

    // ****************************************
    // Next state
    // ****************************************
    assign tx_edge = i_phy_tx_clock_in && !st_ff.txc_d;
    assign rx_edge = i_phy_rx_clock_in && !st_ff.rxc_d;
    // Full duplex: collision is flow control; half: wait for quiet medium.
    assign can_start = i_full_duplex ? !col_s : !(crs_s || col_s);
    assign half_div = (i_mgmt_clock_divider == '0) ? DIV_W'(1)
        : i_mgmt_clock_divider;
    assign mg_tick = (st_ff.mg_div >= half_div - DIV_W'(1));

    always_comb begin
        nxt_st = st_ff;
        nxt_st.txc_d = i_phy_tx_clock_in;
        nxt_st.rxc_d = i_phy_rx_clock_in;
        nxt_st.tx_req = 1'b0;
        nxt_st.rx_done = 1'b0;
        nxt_st.mg_done = 1'b0;
        // Transmit runs on rising edges of the PHY clock.
        if (tx_edge) begin
            case (st_ff.tx_st)
                TXS_IDLE: begin
                    nxt_st.tx_en = 1'b0;
                    if (i_tx_valid && can_start) begin
                        nxt_st.tx_buf = i_tx_byte;
                        nxt_st.tx_last = i_tx_last;
                        nxt_st.tx_st = TXS_LO;
                    end
                end
                TXS_LO: begin
                    nxt_st.tx_nib = st_ff.tx_buf[NIB_W-1:0];
                    nxt_st.tx_en = 1'b1;
                    nxt_st.tx_st = TXS_HI;
                end
                default: begin
                    nxt_st.tx_nib = st_ff.tx_buf[BYTE_W-1:NIB_W];
                    nxt_st.tx_en = 1'b1;
                    // A packet in flight finishes regardless of collision.
                    if (!st_ff.tx_last && i_tx_valid) begin
                        nxt_st.tx_buf = i_tx_byte;
                        nxt_st.tx_last = i_tx_last;
                        nxt_st.tx_st = TXS_LO;
                    end else begin
                        nxt_st.tx_st = TXS_IDLE;
                        nxt_st.tx_req = 1'b1;
                    end
                end
            endcase
        end
        // Receive: pair nibbles low first, flag errors inside the frame.
        if (rx_edge) begin
            nxt_st.rx_dv_d = i_rx_valid_in;
            nxt_st.rx_v = 1'b0;
            if (i_rx_valid_in) begin
                if (st_ff.rx_hi) begin
                    nxt_st.rx_byte = {i_rx_nibble_in, st_ff.rx_lo};
                    nxt_st.rx_v = 1'b1;
                end else begin
                    nxt_st.rx_lo = i_rx_nibble_in;
                end
                nxt_st.rx_hi = !st_ff.rx_hi;
                if (i_rx_error_in) begin
                    nxt_st.rx_err = 1'b1;
                end
            end else begin
                nxt_st.rx_hi = 1'b0;
                if (st_ff.rx_dv_d) begin
                    nxt_st.rx_done = 1'b1;
                    nxt_st.rx_ferr = st_ff.rx_err;
                    nxt_st.rx_err = 1'b0;
                end
            end
        end else begin
            nxt_st.rx_v = 1'b0;
        end
        // Management serial engine.
        case (st_ff.mg_st)
            MGS_IDLE: begin
                nxt_st.mg_clk = 1'b0;
                nxt_st.mg_div = '0;
                if (i_mgmt_start) begin
                    nxt_st.mg_sh = {MGMT_START,
                        i_mgmt_read ? MGMT_OP_RD : MGMT_OP_WR,
                        i_mgmt_phy, i_mgmt_reg, MGMT_TA_WR, i_mgmt_wdata};
                    nxt_st.mg_rd = i_mgmt_read;
                    nxt_st.mg_cnt = '0;
                    nxt_st.mg_st = MGS_SHIFT;
                end
            end
            default: begin
                if (mg_tick) begin
                    nxt_st.mg_div = '0;
                    nxt_st.mg_clk = !st_ff.mg_clk;
                    if (st_ff.mg_clk) begin
                        // Falling edge: move to next bit.
                        nxt_st.mg_sh = {st_ff.mg_sh[MGMT_FRAME_W-2:0], 1'b0};
                        if (st_ff.mg_cnt == 6'(MGMT_FRAME_W - 1)) begin
                            nxt_st.mg_st = MGS_IDLE;
                            nxt_st.mg_done = 1'b1;
                        end
                        nxt_st.mg_cnt = st_ff.mg_cnt + 6'h01;
                    end else if (st_ff.mg_rd
                        && st_ff.mg_cnt >= 6'(MGMT_HDR_W)) begin
                        // Rising edge: sample PHY data on reads.
                        nxt_st.mg_rdata = {st_ff.mg_rdata[MGMT_DATA_W-2:0],
                            i_mgmt_data};
                    end
                end else begin
                    nxt_st.mg_div = st_ff.mg_div + DIV_W'(1);
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_tx_nibble_out = st_ff.tx_nib;
    assign o_tx_enable_out = st_ff.tx_en;
    assign o_tx_error_out = 1'b0;
    assign o_tx_ready = tx_edge && (st_ff.tx_st == TXS_IDLE ? can_start
        : (st_ff.tx_st == TXS_HI && !st_ff.tx_last));
    assign o_tx_dma_req = st_ff.tx_req;
    assign o_rx_valid = st_ff.rx_v;
    assign o_rx_byte = st_ff.rx_byte;
    assign o_rx_done = st_ff.rx_done;
    assign o_rx_dma_req = st_ff.rx_done;
    assign o_rx_frame_err = st_ff.rx_ferr;
    assign o_mgmt_busy = (st_ff.mg_st != MGS_IDLE);
    assign o_mgmt_done = st_ff.mg_done;
    assign o_mgmt_rdata = st_ff.mg_rdata;
    assign o_mgmt_clock_pin = st_ff.mg_clk;
    assign o_mgmt_data = st_ff.mg_sh[MGMT_FRAME_W-1];
    assign o_mgmt_data_oe_n = (st_ff.mg_st != MGS_IDLE) && st_ff.mg_rd
        && (st_ff.mg_cnt >= 6'(MGMT_HDR_W));

    // ****************************************
    // Checks
    // ****************************************
    property p_tx_err_low;
        @(posedge i_clk) disable iff (i_rst) o_tx_error_out == 1'b0;
    endproperty
    a_tx_err_low: assert property (p_tx_err_low)
        else $error("transmit error output went high");

    property p_tx_lo_first;
        @(posedge i_clk) disable iff (i_rst)
        (tx_edge && st_ff.tx_st == TXS_LO) |=>
        o_tx_nibble_out == $past(st_ff.tx_buf[3:0]) && o_tx_enable_out;
    endproperty
    a_tx_lo_first: assert property (p_tx_lo_first)
        else $error("low nibble not sent first");

    property p_fd_col_block;
        @(posedge i_clk) disable iff (i_rst)
        (i_full_duplex && col_s && st_ff.tx_st == TXS_IDLE && tx_edge)
        |=> st_ff.tx_st == TXS_IDLE;
    endproperty
    a_fd_col_block: assert property (p_fd_col_block)
        else $error("packet started under flow control");

    property p_rx_err_mark;
        @(posedge i_clk) disable iff (i_rst)
        (rx_edge && i_rx_valid_in && i_rx_error_in) |=> st_ff.rx_err;
    endproperty
    a_rx_err_mark: assert property (p_rx_err_mark)
        else $error("receive error not recorded");

    property p_rx_pair;
        @(posedge i_clk) disable iff (i_rst)
        (rx_edge && i_rx_valid_in && st_ff.rx_hi) |=>
        o_rx_valid && o_rx_byte[7:4] == $past(i_rx_nibble_in);
    endproperty
    a_rx_pair: assert property (p_rx_pair)
        else $error("receive byte not assembled");

    property p_mg_oe;
        @(posedge i_clk) disable iff (i_rst)
        (o_mgmt_busy && st_ff.mg_cnt < 6'(MGMT_HDR_W)) |-> !o_mgmt_data_oe_n;
    endproperty
    a_mg_oe: assert property (p_mg_oe)
        else $error("management line released in header");

    property p_mg_idle_clk;
        @(posedge i_clk) disable iff (i_rst)
        !o_mgmt_busy |=> !o_mgmt_busy || !o_mgmt_clock_pin;
    endproperty
    a_mg_idle_clk: assert property (p_mg_idle_clk)
        else $error("management clock high at frame start");

    property p_rx_dma;
        @(posedge i_clk) disable iff (i_rst)
        (rx_edge && !i_rx_valid_in && st_ff.rx_dv_d) |=> o_rx_dma_req;
    endproperty
    a_rx_dma: assert property (p_rx_dma)
        else $error("receive request missing");
endmodule

// ==== verification/emu_phy.sv ====
// PHY model: MII clocks, receive frames, transmit capture, MDIO slave.
// Assumes the bench calls send_frame and reads tx_q and mg_bits.
`timescale 1ns/10ps
module emu_phy
    import emu_pkg::*;
(
    // MII
    output logic o_txc,
    output logic o_rxc,
    input wire logic [NIB_W-1:0] i_txn,
    input wire logic i_txen,
    output logic [NIB_W-1:0] o_rxn,
    output logic o_rxdv,
    output logic o_rxer,
    // Management
    input wire logic i_mdc,
    input wire logic i_md,
    input wire logic i_oe_n,
    output logic o_md
);
    // ****
    // Model
    // ****
    localparam logic [MGMT_DATA_W-1:0] RD_WORD = 16'hbeef;
    int hp = 20;
    int k = 0;
    logic drv = 1'b1;
    logic txc = 1'b0;
    logic [NIB_W-1:0] rxn = 4'h0;
    logic rxdv = 1'b0;
    logic rxer = 1'b0;
    logic [NIB_W-1:0] tx_q[$];
    logic [MGMT_FRAME_W-1:0] mg_bits = '0;
    always #(hp) txc = ~txc;
    assign o_txc = txc;
    assign o_rxc = ~txc;
    assign o_rxn = rxn;
    assign o_rxdv = rxdv;
    assign o_rxer = rxer;
    assign o_md = i_oe_n ? drv : i_md;
    always @(posedge txc) begin
        if (i_txen === 1'b1) tx_q.push_back(i_txn);
    end
    always @(posedge i_mdc) begin
        mg_bits <= {mg_bits[MGMT_FRAME_W-2:0], o_md};
    end
    always @(negedge i_mdc) begin
        #1;
        drv = 1'b1;
        if (!i_oe_n) begin
            k = 0;
        end else if (k < MGMT_DATA_W) begin
            drv = RD_WORD[MGMT_DATA_W - 1 - k];
            k++;
        end
    end
    task automatic send_frame(input logic [BYTE_W-1:0] b[$], input int ea);
        for (int i = 0; i < 2 * b.size(); i++) begin
            @(negedge o_rxc);
            rxdv = 1'b1;
            rxn = i[0] ? b[i/2][7:4] : b[i/2][3:0];
            rxer = (i == ea);
        end
        @(negedge o_rxc);
        rxdv = 1'b0;
        rxer = 1'b1;
        rxn = ~rxn;
    endtask
endmodule

// ==== verification/tb.sv ====
// Bench for the MII MAC: packets both ways, deferral, flow control, MDIO.
// Assumes emu_phy models the PHY on the MII and management pins.
`timescale 1ns/10ps
module tb
    import emu_pkg::*;
;
    // ****
    // Bench
    // ****
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_full_duplex = 1'b0;
    logic [DIV_W-1:0] i_mgmt_clock_divider = 8'h14;
    logic i_tx_valid = 1'b0;
    logic [BYTE_W-1:0] i_tx_byte = 8'h00;
    logic i_tx_last = 1'b0;
    logic i_collision_in = 1'b0;
    logic i_carrier_sense_in = 1'b0;
    logic i_mgmt_start = 1'b0;
    logic i_mgmt_read = 1'b0;
    logic [PHY_ADDR_W-1:0] i_mgmt_phy = 5'h0a;
    logic [REG_ADDR_W-1:0] i_mgmt_reg = 5'h13;
    logic [MGMT_DATA_W-1:0] i_mgmt_wdata = 16'hc35a;
    logic i_phy_tx_clock_in, i_phy_rx_clock_in, i_rx_valid_in, i_rx_error_in;
    logic [NIB_W-1:0] i_rx_nibble_in, o_tx_nibble_out;
    logic i_mgmt_data, o_tx_ready, o_tx_dma_req, o_rx_valid, o_rx_done;
    logic o_rx_frame_err, o_rx_dma_req, o_tx_enable_out, o_tx_error_out;
    logic o_mgmt_busy, o_mgmt_done, o_mgmt_clock_pin, o_mgmt_data;
    logic o_mgmt_data_oe_n;
    logic [BYTE_W-1:0] o_rx_byte;
    logic [MGMT_DATA_W-1:0] o_mgmt_rdata;
    logic [BYTE_W-1:0] rx_q[$];
    int bad_count = 0;
    int n_tests = 0;
    int takes = 0, txd = 0, rxn = 0, rxd = 0, mgd = 0, txer = 0;
    int rel, rises, mdc_bad, rise_t, fall_t, hdv;
    emu_mac emu_mac_i (.i_clk, .i_rst, .i_full_duplex, .i_mgmt_clock_divider,
        .i_tx_valid, .i_tx_byte, .i_tx_last, .o_tx_ready, .o_tx_dma_req,
        .o_rx_valid, .o_rx_byte, .o_rx_done, .o_rx_frame_err, .o_rx_dma_req,
        .i_phy_tx_clock_in, .o_tx_nibble_out, .o_tx_enable_out,
        .o_tx_error_out, .i_collision_in, .i_carrier_sense_in,
        .i_phy_rx_clock_in, .i_rx_nibble_in, .i_rx_valid_in, .i_rx_error_in,
        .i_mgmt_start, .i_mgmt_read, .i_mgmt_phy, .i_mgmt_reg, .i_mgmt_wdata,
        .o_mgmt_busy, .o_mgmt_done, .o_mgmt_rdata, .o_mgmt_clock_pin,
        .i_mgmt_data, .o_mgmt_data, .o_mgmt_data_oe_n);
    emu_phy emu_phy_i (.o_txc(i_phy_tx_clock_in), .o_rxc(i_phy_rx_clock_in),
        .i_txn(o_tx_nibble_out), .i_txen(o_tx_enable_out),
        .o_rxn(i_rx_nibble_in), .o_rxdv(i_rx_valid_in),
        .o_rxer(i_rx_error_in), .i_mdc(o_mgmt_clock_pin),
        .i_md(o_mgmt_data), .i_oe_n(o_mgmt_data_oe_n), .o_md(i_mgmt_data));
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        if (o_tx_ready === 1'b1 && i_tx_valid) takes++;
        if (o_tx_dma_req === 1'b1) txd++;
        if (o_rx_done === 1'b1) rxn++;
        if (o_rx_dma_req === 1'b1) rxd++;
        if (o_mgmt_done === 1'b1) mgd++;
        if (o_rx_valid === 1'b1) rx_q.push_back(o_rx_byte);
        if (o_tx_error_out !== 1'b0 && i_rst === 1'b0) txer++;
    end
    always @(o_mgmt_clock_pin) begin
        if (o_mgmt_clock_pin === 1'b1) begin
            rises++;
            if (o_mgmt_data_oe_n === 1'b1) rel++;
            if (rise_t > 0 && ($time - rise_t != 2 * hdv
                || $time - fall_t != hdv)) mdc_bad++;
            rise_t = int'($time);
        end else begin
            fall_t = int'($time);
        end
    end
    task automatic chk(input logic [31:0] got, exp, input string m);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wait_to(ref int c, input int tgt, lim, input string m);
        for (int t = 0; t < lim; t++) begin
            if (c >= tgt) return;
            @(posedge i_clk);
            #1;
        end
        chk(0, 1, m);
        conclude();
    endtask
    task automatic send(input logic [BYTE_W-1:0] b[$], input int ca);
        for (int i = 0; i < b.size(); i++) begin
            @(negedge i_clk);
            if (i == ca) i_collision_in = 1'b1;
            i_tx_valid = 1'b1;
            i_tx_byte = b[i];
            i_tx_last = (i == b.size() - 1);
            wait_to(takes, takes + 1, 3000, "byte not taken");
        end
        @(negedge i_clk);
        i_tx_valid = 1'b0;
    endtask
    task automatic tx_chk(input logic [BYTE_W-1:0] b[$], input int d0);
        wait_to(txd, d0 + 1, 9000, "no tx dma");
        repeat (3) @(posedge i_phy_tx_clock_in);
        chk(emu_phy_i.tx_q.size(), 2 * b.size(), "nibbles");
        foreach (b[i]) begin
            chk(emu_phy_i.tx_q[2*i], b[i][3:0], "low nibble");
            chk(emu_phy_i.tx_q[2*i+1], b[i][7:4], "high nibble");
        end
        emu_phy_i.tx_q.delete();
        chk(txer, 0, "tx error out");
    endtask
    task automatic refuse(input logic [BYTE_W-1:0] v, input string m);
        int t0;
        repeat (3) @(negedge i_clk);
        i_tx_valid = 1'b1;
        i_tx_byte = v;
        i_tx_last = 1'b1;
        t0 = takes;
        repeat (300) @(posedge i_clk);
        chk(takes, t0, m);
    endtask
    task automatic rx_run(input logic [BYTE_W-1:0] b[$], input int ea);
        int r0;
        r0 = rxn + 1;
        rx_q.delete();
        emu_phy_i.send_frame(b, ea);
        wait_to(rxn, r0, 3000, "no rx done");
        chk(rx_q.size(), b.size(), "rx count");
        foreach (b[i]) chk(rx_q[i], b[i], "rx byte");
        chk(rxd, rxn, "rx dma");
        chk(o_rx_frame_err, ea >= 0, "rx error flag");
    endtask
    task automatic t_tx();
        logic [BYTE_W-1:0] q[$] = '{8'ha5, 8'h3c, 8'hf0};
        int d0;
        d0 = txd;
        send(q, -1);
        tx_chk(q, d0);
        $display("test tx_basic done");
    endtask
    task automatic t_defer();
        int d0;
        for (int k = 0; k < 2; k++) begin
            @(negedge i_clk);
            i_carrier_sense_in = (k == 0);
            i_collision_in = (k == 1);
            refuse(8'h5a, "started on busy medium");
            @(negedge i_clk);
            i_carrier_sense_in = 1'b0;
            i_collision_in = 1'b0;
            d0 = txd;
            send('{8'h5a}, -1);
            tx_chk('{8'h5a}, d0);
        end
        $display("test defer done");
    endtask
    task automatic t_flow();
        logic [BYTE_W-1:0] q[$] = '{8'h11, 8'h22, 8'h33, 8'h44};
        int d0;
        @(negedge i_clk);
        i_full_duplex = 1'b1;
        d0 = txd;
        send(q, 1);
        tx_chk(q, d0);
        refuse(8'h77, "started under flow control");
        @(negedge i_clk);
        i_collision_in = 1'b0;
        d0 = txd;
        send('{8'h77}, -1);
        tx_chk('{8'h77}, d0);
        @(negedge i_clk);
        i_full_duplex = 1'b0;
        $display("test flow done");
    endtask
    task automatic t_slow();
        int d0;
        emu_phy_i.hp = 200;
        d0 = txd;
        send('{8'h96}, -1);
        tx_chk('{8'h96}, d0);
        rx_run('{8'h81, 8'he7}, 2);
        emu_phy_i.hp = 20;
        rx_run('{8'h0f, 8'hc3, 8'h5e}, -1);
        $display("test rx done");
    endtask
    task automatic mg_run(input logic rd, input logic [DIV_W-1:0] dv);
        @(negedge i_clk);
        i_mgmt_clock_divider = dv;
        hdv = (dv == 8'h00) ? 10 : 10 * dv;
        i_mgmt_read = rd;
        i_mgmt_start = 1'b1;
        rel = 0;
        rises = 0;
        mdc_bad = 0;
        rise_t = 0;
        @(negedge i_clk);
        i_mgmt_start = 1'b0;
        chk(o_mgmt_busy, 1, "busy");
        wait_to(mgd, mgd + 1, 5000, "no mgmt done");
        chk(o_mgmt_busy, 0, "idle");
        chk(rises, MGMT_FRAME_W, "mdc count");
        chk(mdc_bad, 0, "mdc phases");
        chk(rel, rd ? MGMT_DATA_W : 0, "released bits");
        chk(emu_phy_i.mg_bits[MGMT_FRAME_W-1:MGMT_DATA_W+TA_BITS],
            {MGMT_START, rd ? MGMT_OP_RD : MGMT_OP_WR, i_mgmt_phy, i_mgmt_reg},
            "header");
        if (rd) begin
            chk(o_mgmt_rdata, 16'hbeef, "read data");
        end else begin
            chk(emu_phy_i.mg_bits[17:0], {MGMT_TA_WR, i_mgmt_wdata}, "wr");
        end
        $display("test mgmt done");
    endtask
    initial begin
        repeat (16) @(posedge i_clk);
        @(negedge i_clk);
        i_rst = 1'b0;
        t_tx();
        t_defer();
        t_flow();
        t_slow();
        mg_run(1'b0, 8'h14);
        mg_run(1'b1, 8'h05);
        mg_run(1'b0, 8'h00);
        conclude();
    end
endmodule
